// ===== include/meter_cfg_pkg.sv
package meter_cfg_pkg;

  // ---------------------------------------------------------------
  // register map (indirect measurement port, 7-bit address)
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_MODE_PRIMARY = 7'h0B;
  localparam logic [6:0] ADDR_MODE_SECONDARY = 7'h0C;
  localparam logic [6:0] ADDR_WAVE_CONFIG = 7'h0D;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_MODE_PRIMARY = 8'h06;
  localparam logic [7:0] RST_MODE_SECONDARY = 8'h41;
  localparam logic [7:0] RST_WAVE_CONFIG = 8'h00;

  // ---------------------------------------------------------------
  // primary mode fields
  // ---------------------------------------------------------------
  localparam int SOFT_RESET_POS = 7;
  localparam int ZX_FILTER_BYPASS_POS = 6;
  localparam int INTEGRATOR_POS = 5;
  localparam int SWAP_POS = 4;
  localparam int POWER_DOWN_POS = 3;
  localparam int PULSE_B_DIS_POS = 2;
  localparam int PULSE_A_DIS_POS = 1;
  localparam int HIGHPASS_BYPASS_POS = 0;

  // ---------------------------------------------------------------
  // secondary mode and waveform fields
  // ---------------------------------------------------------------
  localparam int PULSE_B_SRC_LSB = 6;
  localparam int PULSE_A_SRC_LSB = 4;
  localparam int RMS_CHOICE_POS = 3;
  localparam int RMS_SYNC_POS = 2;
  localparam int PERIOD_FREQ_POS = 1;
  localparam int WAVE_B_SRC_LSB = 5;
  localparam int WAVE_A_SRC_LSB = 2;
  localparam int RATE_LSB = 0;

  // pulse source codes (code 1x uses the shared rms choice)
  localparam logic [1:0] SRC_ACTIVE = 2'h0;
  localparam logic [1:0] SRC_REACTIVE = 2'h1;

  // waveform source codes
  localparam logic [2:0] WAVE_CURRENT = 3'h0;
  localparam logic [2:0] WAVE_VOLTAGE = 3'h1;
  localparam logic [2:0] WAVE_ACTIVE = 3'h2;
  localparam logic [2:0] WAVE_REACTIVE = 3'h3;
  localparam logic [2:0] WAVE_APPARENT = 3'h4;
  localparam logic [2:0] WAVE_IRMS = 3'h5;
  localparam int WAVE_A_IRMS_BITS = 24;

  // ---------------------------------------------------------------
  // timing: 819.2 kHz sample base built from the 10 MHz clock
  // ---------------------------------------------------------------
  localparam int CLK_RATE_HZ = 10_000_000;
  localparam int BASE_RATE_DHZ = 8_192_000; // 819.2 kHz in tenths of Hz
  localparam int PHASE_STEP = BASE_RATE_DHZ / 1000;
  localparam int PHASE_MOD = (CLK_RATE_HZ * 10) / 1000;
  localparam int PHASE_W = 17;
  localparam int MIN_RATE_DIV = 32; // divisor for rate code 00
  localparam int RATE_CNT_W = 8;

  // soft reset sequencer
  typedef enum logic [1:0]
  {
    SR_IDLE = 2'b01,
    SR_CLEAR = 2'b10
  } soft_reset_state_t;

endpackage : meter_cfg_pkg

// ===== rtl/energy_meter_mode_config.sv
// Strobed register access was left to the implementer.
module energy_meter_mode_config
#(
  parameter int SAMPLE_W = 24,
  parameter int IRMS_W = 32,
  parameter int SOFT_RESET_CYCLES = 4
)
(
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // datapath samples and rate pulses
  input wire logic [SAMPLE_W-1:0] first_channel_adc,
  input wire logic [SAMPLE_W-1:0] second_channel_adc,
  input wire logic [SAMPLE_W-1:0] active_product,
  input wire logic [SAMPLE_W-1:0] reactive_product,
  input wire logic [SAMPLE_W-1:0] apparent_product,
  input wire logic [IRMS_W-1:0] irms_lpf,
  input wire logic active_rate_pulse,
  input wire logic reactive_rate_pulse,
  input wire logic apparent_rate_pulse,
  input wire logic irms_rate_pulse,
  // configuration towards the datapath
  output logic meas_soft_reset,
  output logic zero_cross_filter_bypass,
  output logic integrator_enable,
  output logic channel_swap,
  output logic adc_power_down,
  output logic highpass_bypass,
  output logic rms_sync_to_crossing,
  output logic period_or_frequency_select,
  // processed channel samples
  output logic [SAMPLE_W-1:0] current_path_sample,
  output logic [SAMPLE_W-1:0] voltage_path_sample,
  // pulse outputs
  output logic pulse_out_a,
  output logic pulse_out_b,
  // waveform samples
  output logic [IRMS_W-1:0] wave_a_sample,
  output logic [IRMS_W-1:0] wave_b_sample,
  output logic wave_a_valid,
  output logic wave_b_valid
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (IRMS_W <= SAMPLE_W || IRMS_W < meter_cfg_pkg::WAVE_A_IRMS_BITS)
    $error("irms width must exceed sample width and be at least 24");
  if (SOFT_RESET_CYCLES < 1 || SOFT_RESET_CYCLES > 255)
    $error("soft reset cycles must be 1 to 255");

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  meter_cfg_pkg::soft_reset_state_t sr_state_ff;
  meter_cfg_pkg::soft_reset_state_t nxt_sr_state;
  logic [7:0] sr_cnt_ff;
  logic [6:0] mode_primary_ff;
  logic [7:0] mode_secondary_ff;
  logic [7:0] wave_config_ff;
  logic [7:0] rdata_ff;
  logic pulse_a_ff;
  logic pulse_b_ff;
  logic [SAMPLE_W-1:0] cur_ff;
  logic [SAMPLE_W-1:0] volt_ff;
  logic [meter_cfg_pkg::PHASE_W-1:0] phase_ff;
  logic base_tick_ff;
  logic [meter_cfg_pkg::RATE_CNT_W-1:0] rate_cnt_ff;
  logic [meter_cfg_pkg::RATE_CNT_W-1:0] rate_last;
  logic [IRMS_W-1:0] wave_a_ff;
  logic [IRMS_W-1:0] wave_b_ff;
  logic wave_a_vld_ff;
  logic wave_b_vld_ff;
  logic sr_busy;
  logic sr_start;
  logic [1:0] src_a;
  logic [1:0] src_b;
  logic [2:0] wsel_a;
  logic [2:0] wsel_b;
  logic sample_strobe;
  logic [meter_cfg_pkg::PHASE_W:0] phase_sum;

  localparam logic [7:0] SR_LAST = 8'(SOFT_RESET_CYCLES - 1);

  assign sr_busy = (sr_state_ff == meter_cfg_pkg::SR_CLEAR);
  assign sr_start = reg_wr && !sr_busy && (reg_addr == meter_cfg_pkg::ADDR_MODE_PRIMARY)
                    && reg_wdata[meter_cfg_pkg::SOFT_RESET_POS];
  assign src_a = mode_secondary_ff[meter_cfg_pkg::PULSE_A_SRC_LSB +: 2];
  assign src_b = mode_secondary_ff[meter_cfg_pkg::PULSE_B_SRC_LSB +: 2];
  assign wsel_a = wave_config_ff[meter_cfg_pkg::WAVE_A_SRC_LSB +: 3];
  assign wsel_b = wave_config_ff[meter_cfg_pkg::WAVE_B_SRC_LSB +: 3];

  // ---------------------------------------------------------------
  // soft reset sequencer
  // ---------------------------------------------------------------
  // next state: start on a write of the reset bit, leave when the count ends
  always_comb
  begin
    nxt_sr_state = sr_state_ff;
    case (sr_state_ff)
      meter_cfg_pkg::SR_IDLE:
        if (sr_start)
          nxt_sr_state = meter_cfg_pkg::SR_CLEAR;
      meter_cfg_pkg::SR_CLEAR:
        if (sr_cnt_ff == SR_LAST)
          nxt_sr_state = meter_cfg_pkg::SR_IDLE;
      default: nxt_sr_state = meter_cfg_pkg::SR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      sr_state_ff <= meter_cfg_pkg::SR_IDLE;
    else
      sr_state_ff <= nxt_sr_state;
  end

  // hold count; restarts from zero each time the sequence begins
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      sr_cnt_ff <= 8'h00;
    else if (sr_busy)
      sr_cnt_ff <= sr_cnt_ff + 8'h01;
    else
      sr_cnt_ff <= 8'h00;
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // writes during the clear window are dropped so defaults stand intact
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mode_primary_ff <= meter_cfg_pkg::RST_MODE_PRIMARY[6:0];
      mode_secondary_ff <= meter_cfg_pkg::RST_MODE_SECONDARY;
      wave_config_ff <= meter_cfg_pkg::RST_WAVE_CONFIG;
    end
    else if (sr_start || sr_busy)
    begin
      mode_primary_ff <= meter_cfg_pkg::RST_MODE_PRIMARY[6:0];
      mode_secondary_ff <= meter_cfg_pkg::RST_MODE_SECONDARY;
      wave_config_ff <= meter_cfg_pkg::RST_WAVE_CONFIG;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        meter_cfg_pkg::ADDR_MODE_PRIMARY: mode_primary_ff <= reg_wdata[6:0];
        meter_cfg_pkg::ADDR_MODE_SECONDARY: mode_secondary_ff <= reg_wdata;
        meter_cfg_pkg::ADDR_WAVE_CONFIG: wave_config_ff <= reg_wdata;
        default: mode_primary_ff <= mode_primary_ff;
      endcase
    end
  end

  // read data: reset bit shows the sequence in progress, unmapped reads zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_ff <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        meter_cfg_pkg::ADDR_MODE_PRIMARY: rdata_ff <= {sr_busy, mode_primary_ff};
        meter_cfg_pkg::ADDR_MODE_SECONDARY: rdata_ff <= mode_secondary_ff;
        meter_cfg_pkg::ADDR_WAVE_CONFIG: rdata_ff <= wave_config_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
    else
      rdata_ff <= 8'h00;
  end

  // ---------------------------------------------------------------
  // level controls towards the datapath
  // ---------------------------------------------------------------
  assign reg_rdata = rdata_ff;
  assign zero_cross_filter_bypass = mode_primary_ff[meter_cfg_pkg::ZX_FILTER_BYPASS_POS];
  assign integrator_enable = mode_primary_ff[meter_cfg_pkg::INTEGRATOR_POS];
  assign channel_swap = mode_primary_ff[meter_cfg_pkg::SWAP_POS];
  assign adc_power_down = mode_primary_ff[meter_cfg_pkg::POWER_DOWN_POS];
  assign highpass_bypass = mode_primary_ff[meter_cfg_pkg::HIGHPASS_BYPASS_POS];
  assign rms_sync_to_crossing = mode_secondary_ff[meter_cfg_pkg::RMS_SYNC_POS];
  assign period_or_frequency_select = mode_secondary_ff[meter_cfg_pkg::PERIOD_FREQ_POS];
  assign meas_soft_reset = sr_state_ff[1]; // one-hot bit of the clear state

  // ---------------------------------------------------------------
  // channel routing
  // ---------------------------------------------------------------
  // powered-down converters give zeros so stale codes do not leak on
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cur_ff <= '0;
      volt_ff <= '0;
    end
    else if (adc_power_down)
    begin
      cur_ff <= '0;
      volt_ff <= '0;
    end
    else if (channel_swap)
    begin
      cur_ff <= second_channel_adc;
      volt_ff <= first_channel_adc;
    end
    else
    begin
      cur_ff <= first_channel_adc;
      volt_ff <= second_channel_adc;
    end
  end

  assign current_path_sample = cur_ff;
  assign voltage_path_sample = volt_ff;

  // ---------------------------------------------------------------
  // pulse output steering
  // ---------------------------------------------------------------
  // one choice bit serves both outputs, so mixed va/rms cannot be set
  function automatic logic pick_pulse(input logic [1:0] src, input logic rms_choice,
                                      input logic act, input logic react,
                                      input logic app, input logic rms);
    logic res;
    res = 1'b0;
    case (src)
      meter_cfg_pkg::SRC_ACTIVE: res = act;
      meter_cfg_pkg::SRC_REACTIVE: res = react;
      default: res = rms_choice ? rms : app;
    endcase
    return res;
  endfunction : pick_pulse

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pulse_a_ff <= 1'b0;
      pulse_b_ff <= 1'b0;
    end
    else
    begin
      pulse_a_ff <= !mode_primary_ff[meter_cfg_pkg::PULSE_A_DIS_POS]
                    && pick_pulse(src_a, mode_secondary_ff[meter_cfg_pkg::RMS_CHOICE_POS],
                                  active_rate_pulse, reactive_rate_pulse,
                                  apparent_rate_pulse, irms_rate_pulse);
      pulse_b_ff <= !mode_primary_ff[meter_cfg_pkg::PULSE_B_DIS_POS]
                    && pick_pulse(src_b, mode_secondary_ff[meter_cfg_pkg::RMS_CHOICE_POS],
                                  active_rate_pulse, reactive_rate_pulse,
                                  apparent_rate_pulse, irms_rate_pulse);
    end
  end

  assign pulse_out_a = pulse_a_ff;
  assign pulse_out_b = pulse_b_ff;

  // ---------------------------------------------------------------
  // waveform sample rate
  // ---------------------------------------------------------------
  // fractional accumulator: 10 MHz is no integer multiple of 819.2 kHz,
  // so ticks jitter by one clock but average to the exact base rate
  assign phase_sum = {1'b0, phase_ff} + (meter_cfg_pkg::PHASE_W + 1)'(meter_cfg_pkg::PHASE_STEP);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_ff <= '0;
      base_tick_ff <= 1'b0;
    end
    else if (phase_sum >= (meter_cfg_pkg::PHASE_W + 1)'(meter_cfg_pkg::PHASE_MOD))
    begin
      phase_ff <= meter_cfg_pkg::PHASE_W'(phase_sum
                  - (meter_cfg_pkg::PHASE_W + 1)'(meter_cfg_pkg::PHASE_MOD));
      base_tick_ff <= 1'b1;
    end
    else
    begin
      phase_ff <= meter_cfg_pkg::PHASE_W'(phase_sum);
      base_tick_ff <= 1'b0;
    end
  end

  // divider terminal count: 32 << code, minus one
  assign rate_last = meter_cfg_pkg::RATE_CNT_W'((meter_cfg_pkg::MIN_RATE_DIV
                     << wave_config_ff[meter_cfg_pkg::RATE_LSB +: 2]) - 1);
  // >= keeps a rate change to a faster setting from overrunning the wrap
  assign sample_strobe = base_tick_ff && (rate_cnt_ff >= rate_last);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rate_cnt_ff <= '0;
    else if (sample_strobe)
      rate_cnt_ff <= '0;
    else if (base_tick_ff)
      rate_cnt_ff <= rate_cnt_ff + 1'b1;
  end

  // ---------------------------------------------------------------
  // waveform source selection
  // ---------------------------------------------------------------
  function automatic logic [IRMS_W-1:0] sext(input logic [SAMPLE_W-1:0] v);
    return {{(IRMS_W-SAMPLE_W){v[SAMPLE_W-1]}}, v};
  endfunction : sext

  // rms_low keeps only the low 24 bits of the rms filter for wave a
  function automatic logic [IRMS_W-1:0] pick_wave(input logic [2:0] code,
                                                  input logic rms_low);
    logic [IRMS_W-1:0] res;
    res = '0;
    case (code)
      meter_cfg_pkg::WAVE_CURRENT: res = sext(cur_ff);
      meter_cfg_pkg::WAVE_VOLTAGE: res = sext(volt_ff);
      meter_cfg_pkg::WAVE_ACTIVE: res = sext(active_product);
      meter_cfg_pkg::WAVE_REACTIVE: res = sext(reactive_product);
      meter_cfg_pkg::WAVE_APPARENT: res = sext(apparent_product);
      meter_cfg_pkg::WAVE_IRMS:
      begin
        res = irms_lpf;
        if (rms_low)
          res = {{(IRMS_W-meter_cfg_pkg::WAVE_A_IRMS_BITS){1'b0}},
                 irms_lpf[meter_cfg_pkg::WAVE_A_IRMS_BITS-1:0]};
      end
      default: res = '0;
    endcase
    return res;
  endfunction : pick_wave

  // reserved codes give no sample: data hold and valid stays low
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wave_a_ff <= '0;
      wave_a_vld_ff <= 1'b0;
    end
    else if (sample_strobe && wsel_a <= meter_cfg_pkg::WAVE_IRMS)
    begin
      wave_a_ff <= pick_wave(wsel_a, 1'b1);
      wave_a_vld_ff <= 1'b1;
    end
    else
      wave_a_vld_ff <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wave_b_ff <= '0;
      wave_b_vld_ff <= 1'b0;
    end
    else if (sample_strobe && wsel_b <= meter_cfg_pkg::WAVE_IRMS)
    begin
      wave_b_ff <= pick_wave(wsel_b, 1'b0);
      wave_b_vld_ff <= 1'b1;
    end
    else
      wave_b_vld_ff <= 1'b0;
  end

  assign wave_a_sample = wave_a_ff;
  assign wave_b_sample = wave_b_ff;
  assign wave_a_valid = wave_a_vld_ff;
  assign wave_b_valid = wave_b_vld_ff;

endmodule : energy_meter_mode_config

// ===== verif/mode_cfg_chk.sv
module mode_cfg_chk
#(
  parameter int SAMPLE_W = 24,
  parameter int SOFT_RESET_CYCLES = 4
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [SAMPLE_W-1:0] first_channel_adc,
  input wire logic active_rate_pulse,
  input wire logic reactive_rate_pulse,
  input wire logic apparent_rate_pulse,
  input wire logic irms_rate_pulse,
  input wire logic meas_soft_reset,
  input wire logic zero_cross_filter_bypass,
  input wire logic integrator_enable,
  input wire logic channel_swap,
  input wire logic adc_power_down,
  input wire logic highpass_bypass,
  input wire logic rms_sync_to_crossing,
  input wire logic period_or_frequency_select,
  input wire logic [SAMPLE_W-1:0] current_path_sample,
  input wire logic [SAMPLE_W-1:0] voltage_path_sample,
  input wire logic pulse_out_a,
  input wire logic pulse_out_b,
  input wire logic wave_b_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sr_len_ff;
  logic [4:0] pri_cfg;
  logic wr_pri;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ---------------------------------------------------------------
  // helper terms
  // ---------------------------------------------------------------
  // cycles spent in the running soft reset, cleared while idle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      sr_len_ff <= 8'h00;
    else if (meas_soft_reset)
      sr_len_ff <= sr_len_ff + 8'h01;
    else
      sr_len_ff <= 8'h00;
  end

  // primary fields as they leave the block, and primary writes
  assign pri_cfg = {zero_cross_filter_bypass, integrator_enable, channel_swap,
                    adc_power_down, highpass_bypass};
  assign wr_pri = reg_wr && reg_addr == meter_cfg_pkg::ADDR_MODE_PRIMARY;

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  sr_start_a: assert property (wr_pri && reg_wdata[7] && !meas_soft_reset |=> meas_soft_reset)
    else $error("soft reset did not start");
  sr_defaults_a: assert property ($rose(meas_soft_reset) |-> pri_cfg == 5'h00
    && !rms_sync_to_crossing && !period_or_frequency_select)
    else $error("soft reset left configuration set");
  sr_length_a: assert property ($fell(meas_soft_reset) |-> sr_len_ff == SOFT_RESET_CYCLES)
    else $error("soft reset length wrong");
  sr_pulses_a: assert property (meas_soft_reset && $past(meas_soft_reset)
    |-> !pulse_out_a && !pulse_out_b)
    else $error("pulse output active during soft reset");
  pri_follow_a: assert property (wr_pri && !reg_wdata[7] && !meas_soft_reset
    |=> pri_cfg == $past({reg_wdata[6:3], reg_wdata[0]}))
    else $error("primary fields do not follow write");
  sec_follow_a: assert property (reg_wr && reg_addr == meter_cfg_pkg::ADDR_MODE_SECONDARY
    && !meas_soft_reset |=> {rms_sync_to_crossing, period_or_frequency_select} == $past(reg_wdata[2:1]))
    else $error("secondary fields do not follow write");
  pulse_cause_a: assert property (pulse_out_a || pulse_out_b |-> $past(active_rate_pulse
    || reactive_rate_pulse || apparent_rate_pulse || irms_rate_pulse))
    else $error("pulse output without rate pulse");
  path_plain_a: assert property (!adc_power_down && !channel_swap
    && $stable({adc_power_down, channel_swap}) |-> current_path_sample == $past(first_channel_adc))
    else $error("current path not fed by first channel");
  path_swap_a: assert property (!adc_power_down && channel_swap
    && $stable({adc_power_down, channel_swap}) |-> voltage_path_sample == $past(first_channel_adc))
    else $error("swap did not exchange channels");
  path_down_a: assert property (adc_power_down && $past(adc_power_down)
    |-> current_path_sample == '0 && voltage_path_sample == '0)
    else $error("powered down channel still delivers data");
  wave_gap_a: assert property ($rose(wave_b_valid) |=> !wave_b_valid [*8])
    else $error("waveform samples too close");
endmodule : mode_cfg_chk

bind energy_meter_mode_config mode_cfg_chk #(.SAMPLE_W(SAMPLE_W),
  .SOFT_RESET_CYCLES(SOFT_RESET_CYCLES)) u_chk (.*);

// ===== verif/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SR_N = 8;
  // addr, write data, expected readback
  localparam logic [22:0] ROWS [7] = '{{7'h0B, 8'h79, 8'h79}, {7'h0B, 8'h00, 8'h00},
    {7'h0C, 8'hFE, 8'hFE}, {7'h0C, 8'h01, 8'h01}, {7'h0D, 8'hFF, 8'hFF},
    {7'h0D, 8'h00, 8'h00}, {7'h0E, 8'h5A, 8'h00}};
  // waveform sample expected for source codes 000..101 (wave b view)
  localparam logic [31:0] WEXP [6] = '{32'hFF876543, 32'h00012345, 32'hFF800001,
    32'h007FFFFF, 32'hFFC00000, 32'hFEDCBA98};
  logic clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [23:0] first_channel_adc = 24'h0, second_channel_adc = 24'h0;
  logic [23:0] active_product = 24'h0, reactive_product = 24'h0, apparent_product = 24'h0;
  logic [31:0] irms_lpf = 32'h0, wave_a_sample, wave_b_sample;
  logic active_rate_pulse = 1'b0, reactive_rate_pulse = 1'b0;
  logic apparent_rate_pulse = 1'b0, irms_rate_pulse = 1'b0;
  logic meas_soft_reset, zero_cross_filter_bypass, integrator_enable, channel_swap;
  logic adc_power_down, highpass_bypass, rms_sync_to_crossing, period_or_frequency_select;
  logic [23:0] current_path_sample, voltage_path_sample;
  logic pulse_out_a, pulse_out_b, wave_a_valid, wave_b_valid;
  int n_fail = 0, check_count = 0, vb_cnt = 0, n, lo, hi;

  energy_meter_mode_config #(.SOFT_RESET_CYCLES(SR_N)) DUT (.*);

  // ---------------------------------------------------------------
  // clock, sample counter, watchdog
  // ---------------------------------------------------------------
  always #50 clk = ~clk;

  // counts wave b samples so reserved codes can be seen to stay silent
  always @(negedge clk)
  begin
    if (wave_b_valid === 1'b1)
      vb_cnt++;
  end

  // the wave sweep dominates the run time, well below this span
  initial
  begin
    repeat (60000) @(posedge clk);
    n_fail++;
    conclude();
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic conclude();
    if (n_fail == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t register read %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t output %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [6:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk_reg(reg_rdata, exp);
  endtask : rdc

  task automatic defaults();
    rdc(meter_cfg_pkg::ADDR_MODE_PRIMARY, 8'h06);
    rdc(meter_cfg_pkg::ADDR_MODE_SECONDARY, 8'h41);
    rdc(meter_cfg_pkg::ADDR_WAVE_CONFIG, 8'h00);
  endtask : defaults

  // one rate pulse of kind k, outputs looked at one cycle later
  task automatic fire(input int k, input logic ea, input logic eb);
    @(posedge clk);
    {irms_rate_pulse, apparent_rate_pulse, reactive_rate_pulse, active_rate_pulse} <= 4'(1 << k);
    @(posedge clk);
    {irms_rate_pulse, apparent_rate_pulse, reactive_rate_pulse, active_rate_pulse} <= 4'h0;
    @(negedge clk);
    chk_val({30'h0, pulse_out_b, pulse_out_a}, {30'h0, eb, ea});
  endtask : fire

  task automatic wait_va();
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (wave_a_valid !== 1'b1 && n < 4000);
  endtask : wait_va

  function automatic int src_idx(input logic [1:0] s, input logic c);
    return s[1] ? (c ? 3 : 2) : int'(s[0]);
  endfunction : src_idx

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    defaults();
    chk_val({24'h0, pulse_out_a, pulse_out_b, zero_cross_filter_bypass, adc_power_down,
      highpass_bypass, channel_swap, rms_sync_to_crossing, period_or_frequency_select}, 0);
    // register rows: write, read back, fields at the ports
    foreach (ROWS[i])
    begin
      wr(ROWS[i][22:16], ROWS[i][15:8]);
      rdc(ROWS[i][22:16], ROWS[i][7:0]);
      if (ROWS[i][22:16] == meter_cfg_pkg::ADDR_MODE_PRIMARY)
        chk_val({zero_cross_filter_bypass, integrator_enable, channel_swap, adc_power_down,
          highpass_bypass}, {ROWS[i][14:11], ROWS[i][8]});
      if (ROWS[i][22:16] == meter_cfg_pkg::ADDR_MODE_SECONDARY)
        chk_val({rms_sync_to_crossing, period_or_frequency_select}, ROWS[i][10:9]);
    end
    // every pulse source and rms choice, both outputs sharing the choice
    wr(meter_cfg_pkg::ADDR_MODE_PRIMARY, 8'h00);
    for (int s = 0; s < 4; s++)
      for (int c = 0; c < 2; c++)
      begin
        wr(meter_cfg_pkg::ADDR_MODE_SECONDARY, {2'(s ^ 1), 2'(s), 1'(c), 3'b001});
        for (int k = 0; k < 4; k++)
          fire(k, k == src_idx(2'(s), 1'(c)), k == src_idx(2'(s ^ 1), 1'(c)));
      end
    // disables, each alone and together; both sources are irms now
    for (int d = 1; d < 4; d++)
    begin
      wr(meter_cfg_pkg::ADDR_MODE_PRIMARY, 8'(d << 1));
      fire(3, !d[0], !d[1]);
    end
    // channel routing: plain, swapped, powered down
    @(posedge clk);
    first_channel_adc <= 24'h876543;
    second_channel_adc <= 24'h012345;
    for (int m = 0; m < 3; m++)
    begin
      wr(meter_cfg_pkg::ADDR_MODE_PRIMARY, m == 0 ? 8'h00 : (m == 1 ? 8'h10 : 8'h08));
      repeat (3) @(negedge clk);
      chk_val(current_path_sample, m == 0 ? 24'h876543 : (m == 1 ? 24'h012345 : 24'h0));
      chk_val(voltage_path_sample, m == 0 ? 24'h012345 : (m == 1 ? 24'h876543 : 24'h0));
    end
    // every wave source on both outputs, every sample rate
    wr(meter_cfg_pkg::ADDR_MODE_PRIMARY, 8'h00);
    active_product <= 24'h800001;
    reactive_product <= 24'h7FFFFF;
    apparent_product <= 24'hC00000;
    irms_lpf <= 32'hFEDCBA98;
    for (int i = 0; i < 6; i++)
    begin
      wr(meter_cfg_pkg::ADDR_WAVE_CONFIG, {3'(5 - i), 3'(i), 2'(i % 4)});
      lo = ((32 << (i % 4)) * 100000) / 8192;
      hi = ((32 << (i % 4)) * 100000 + 8191) / 8192;
      wait_va();
      wait_va();
      chk_val(32'(n >= lo && n <= hi), 1);
      chk_val(wave_a_sample, i == 5 ? 32'h00DCBA98 : WEXP[i]);
      chk_val(wave_b_sample, WEXP[5 - i]);
    end
    // reserved wave b code: no samples, old data held
    wr(meter_cfg_pkg::ADDR_WAVE_CONFIG, 8'hC8);
    wait_va();
    @(posedge clk);
    vb_cnt = 0;
    wait_va();
    chk_val(vb_cnt, 0);
    chk_val(wave_b_sample, WEXP[0]);
    // soft reset: busy readback, dropped write, defaults afterwards
    wr(meter_cfg_pkg::ADDR_MODE_PRIMARY, 8'h79);
    wr(meter_cfg_pkg::ADDR_MODE_SECONDARY, 8'hFE);
    wr(meter_cfg_pkg::ADDR_WAVE_CONFIG, 8'hFF);
    wr(meter_cfg_pkg::ADDR_MODE_PRIMARY, 8'h80);
    rdc(meter_cfg_pkg::ADDR_MODE_PRIMARY, 8'h86);
    wr(meter_cfg_pkg::ADDR_MODE_SECONDARY, 8'h00);
    // every rate pulse high while the clear runs: the outputs must stay disabled
    {irms_rate_pulse, apparent_rate_pulse, reactive_rate_pulse, active_rate_pulse} <= 4'hF;
    n = 0;
    while (meas_soft_reset !== 1'b0 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    defaults();
    chk_val({pulse_out_b, pulse_out_a}, 0);
    // second hardware reset in mid-run
    wr(meter_cfg_pkg::ADDR_MODE_PRIMARY, 8'h79);
    first_channel_adc <= 24'h0;
    {irms_rate_pulse, apparent_rate_pulse, reactive_rate_pulse, active_rate_pulse} <= 4'h0;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    defaults();
    chk_val({zero_cross_filter_bypass, integrator_enable, channel_swap}, 0);
    conclude();
  end
endmodule : tb
